// >>> vtlih_handler.sv
/*
  vectored two-level interrupt handler: pending flags, enables, priorities,
  arbitration, long-call request to the sequencer and nesting state.
  assumes the sequencer pulses instr_done_i at each instruction boundary,
  return_from_interrupt_i with it when that instruction is a return-from-interrupt, and
  signals no boundary while long_call_o is high.
*/
`timescale 1ns/100ps
`include "vtlih_cfg.svh"
module vtlih_handler
  import vtlih_pkg::*;
(
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire vtlih_pkg::vtlih_byte_t wr_data_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output vtlih_pkg::vtlih_byte_t rd_data_o, // read data, cycle after rd_i
  input wire vtlih_pkg::vtlih_src_t src_set_i, // peripheral flag set pulses
  input wire logic ext_irq_pin_zero_i, // ext0 pin, active low
  input wire logic ext_irq_pin_one_i, // ext1 pin, active low
  input wire logic ext6_pin_i, // ext6 pin
  input wire logic ext7_pin_i, // ext7 pin
  input wire logic instr_done_i, // current instruction completes
  input wire logic return_from_interrupt_i, // that instruction is return_from_interrupt
  output logic long_call_o, // long_call in progress
  output vtlih_pkg::vtlih_vec_t vector_o // long_call target
);
  import vtlih_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  vtlih_pin_if pins ();
  vtlih_pin_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i({ext7_pin_i, ext6_pin_i, ext_irq_pin_one_i, ext_irq_pin_zero_i}),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  vtlih_byte_t pri_en_r, ext_en1_r, ext_en2_r;
  vtlih_byte_t pri_prio_r, ext_prio1_r, ext_prio2_r;
  logic trig0_r, trig1_r, pol6_r, pol7_r;
  vtlih_src_t pend_r, pend_nxt;
  vtlih_src_t en_vec, prio_vec, hw_set, sw_mask, sw_val, auto_clr;
  vtlih_state_t state_r;
  logic [2:0] call_cnt_r;
  logic act_hi_r, act_lo_r;
  logic req_valid_r, req_hi_r;
  vtlih_idx_t req_idx_r;
  vtlih_byte_t rd_nxt;
  logic fire, glob_en;

  assign glob_en = pri_en_r[`VTLIH_GLOBAL_EN_BIT];
  assign en_vec = {ext_en2_r, ext_en1_r, pri_en_r[5:0]};
  assign prio_vec = {ext_prio2_r, ext_prio1_r, pri_prio_r[5:0]};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pri_en_r <= `VTLIH_RST_BYTE;
      ext_en1_r <= `VTLIH_RST_BYTE;
      ext_en2_r <= `VTLIH_RST_BYTE;
    end else if (wr_i) begin
      if (addr_i == `VTLIH_ADDR_PRI_EN) begin
        pri_en_r <= wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_EXT_EN1) begin
        ext_en1_r <= wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_EXT_EN2) begin
        ext_en2_r <= wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pri_prio_r <= `VTLIH_RST_BYTE;
      ext_prio1_r <= `VTLIH_RST_BYTE;
      ext_prio2_r <= `VTLIH_RST_BYTE;
    end else if (wr_i) begin
      if (addr_i == `VTLIH_ADDR_PRI_PRIO) begin
        pri_prio_r <= wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_EXT_PRIO1) begin
        ext_prio1_r <= wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_EXT_PRIO2) begin
        ext_prio2_r <= wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trig0_r <= 1'b0;
      trig1_r <= 1'b0;
      pol6_r <= 1'b0;
      pol7_r <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `VTLIH_ADDR_TIMER_CTRL) begin
        trig0_r <= wr_data_i[`VTLIH_TC_TRIG0_BIT];
        trig1_r <= wr_data_i[`VTLIH_TC_TRIG1_BIT];
      end else if (addr_i == `VTLIH_ADDR_PORT3_FLAG) begin
        pol6_r <= wr_data_i[`VTLIH_P3_POL6_BIT];
        pol7_r <= wr_data_i[`VTLIH_P3_POL7_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags
  always_comb begin
    hw_set = src_set_i & ~`VTLIH_PIN_SRC_MASK;
    hw_set[`VTLIH_SRC_EXT0] = pins.fall[0];
    hw_set[`VTLIH_SRC_EXT1] = pins.fall[1];
    hw_set[`VTLIH_SRC_EXT6] = pol6_r ? pins.rise[2] : pins.fall[2];
    hw_set[`VTLIH_SRC_EXT7] = pol7_r ? pins.rise[3] : pins.fall[3];
  end

  always_comb begin
    sw_mask = '0;
    sw_val = '0;
    if (wr_i) begin
      if (addr_i == `VTLIH_ADDR_PEND0) begin
        sw_mask[7:0] = 8'hff;
        sw_val[7:0] = wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_PEND1) begin
        sw_mask[15:8] = 8'hff;
        sw_val[15:8] = wr_data_i;
      end else if (addr_i == `VTLIH_ADDR_PEND2) begin
        sw_mask[21:16] = 6'h3f;
        sw_val[21:16] = wr_data_i[5:0];
      end else if (addr_i == `VTLIH_ADDR_TIMER_CTRL) begin
        sw_mask[3:0] = 4'hf;
        sw_val[`VTLIH_SRC_EXT0] = wr_data_i[`VTLIH_TC_PEND0_BIT];
        sw_val[`VTLIH_SRC_TMR0] = wr_data_i[`VTLIH_TC_TMR0_BIT];
        sw_val[`VTLIH_SRC_EXT1] = wr_data_i[`VTLIH_TC_PEND1_BIT];
        sw_val[`VTLIH_SRC_TMR1] = wr_data_i[`VTLIH_TC_TMR1_BIT];
      end else if (addr_i == `VTLIH_ADDR_PORT3_FLAG) begin
        sw_mask[19:18] = 2'h3;
        sw_val[`VTLIH_SRC_EXT6] = wr_data_i[`VTLIH_P3_PEND6_BIT];
        sw_val[`VTLIH_SRC_EXT7] = wr_data_i[`VTLIH_P3_PEND7_BIT];
      end
    end
  end

  always_comb begin
    auto_clr = '0;
    if (fire) begin
      auto_clr[req_idx_r] = 1'b1;
    end
    auto_clr = auto_clr & `VTLIH_AUTO_CLR_MASK;
  end

  genvar k;
  generate
    for (k = 0; k < `VTLIH_NUM_SRC; k++) begin : gen_pend
      always_comb begin
        if (sw_mask[k]) begin
          pend_nxt[k] = hw_set[k] | sw_val[k];
        end else begin
          pend_nxt[k] = hw_set[k] | (pend_r[k] & ~auto_clr[k]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      if (!trig0_r) begin
        pend_r[`VTLIH_SRC_EXT0] <= !pins.level[0];
      end
      if (!trig1_r) begin
        pend_r[`VTLIH_SRC_EXT1] <= !pins.level[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration, sampled every clock
  function automatic logic [5:0] vtlih_pick(input vtlih_src_t v);
    logic [5:0] res;
    res = 6'h00;
    for (int i = `VTLIH_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  vtlih_src_t elig, elig_hi, elig_lo;
  logic [5:0] pick_hi, pick_lo;
  always_comb begin
    elig = glob_en ? (pend_r & en_vec) : '0;
    elig_hi = act_hi_r ? '0 : (elig & prio_vec);
    elig_lo = (act_hi_r || act_lo_r) ? '0 : (elig & ~prio_vec);
    pick_hi = vtlih_pick(elig_hi);
    pick_lo = vtlih_pick(elig_lo);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      req_valid_r <= 1'b0;
      req_hi_r <= 1'b0;
      req_idx_r <= '0;
    end else begin
      req_valid_r <= pick_hi[5] || pick_lo[5];
      req_hi_r <= pick_hi[5];
      req_idx_r <= pick_hi[5] ? pick_hi[4:0] : pick_lo[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // long call sequencing and nesting
  // a boundary that is a return never vectors, so the next instruction runs
  assign fire = (state_r == VTLIH_ST_RUN) && instr_done_i && !return_from_interrupt_i && req_valid_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= VTLIH_ST_RUN;
      call_cnt_r <= 3'd0;
      vector_o <= `VTLIH_RESET_VEC;
    end else begin
      case (state_r)
        VTLIH_ST_RUN: begin
          if (fire) begin
            state_r <= VTLIH_ST_CALL;
            call_cnt_r <= `VTLIH_LONG_CALL_CYCLES - 3'd1;
            vector_o <= `VTLIH_VEC_BASE + {8'h00, req_idx_r, 3'b000};
          end
        end
        VTLIH_ST_CALL: begin
          call_cnt_r <= call_cnt_r - 3'd1;
          if (call_cnt_r == 3'd0) begin
            state_r <= VTLIH_ST_RUN;
          end
        end
        default: begin
          state_r <= VTLIH_ST_RUN;
        end
      endcase
    end
  end

  assign long_call_o = (state_r == VTLIH_ST_CALL);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (fire) begin
      if (req_hi_r) begin
        act_hi_r <= 1'b1;
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (instr_done_i && return_from_interrupt_i) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0;
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_comb begin
    rd_nxt = 8'h00;
    if (addr_i == `VTLIH_ADDR_PRI_EN) begin
      rd_nxt = pri_en_r;
    end else if (addr_i == `VTLIH_ADDR_EXT_EN1) begin
      rd_nxt = ext_en1_r;
    end else if (addr_i == `VTLIH_ADDR_EXT_EN2) begin
      rd_nxt = ext_en2_r;
    end else if (addr_i == `VTLIH_ADDR_PRI_PRIO) begin
      rd_nxt = pri_prio_r | `VTLIH_PRI_PRIO_UNUSED;
    end else if (addr_i == `VTLIH_ADDR_EXT_PRIO1) begin
      rd_nxt = ext_prio1_r;
    end else if (addr_i == `VTLIH_ADDR_EXT_PRIO2) begin
      rd_nxt = ext_prio2_r;
    end else if (addr_i == `VTLIH_ADDR_TIMER_CTRL) begin
      rd_nxt = {pend_r[3], 1'b0, pend_r[1], 1'b0, pend_r[2], trig1_r, pend_r[0], trig0_r};
    end else if (addr_i == `VTLIH_ADDR_PORT3_FLAG) begin
      rd_nxt = {1'b0, pend_r[19], pend_r[18], 1'b0, pol7_r, pol6_r, 2'b00};
    end else if (addr_i == `VTLIH_ADDR_PEND0) begin
      rd_nxt = pend_r[7:0];
    end else if (addr_i == `VTLIH_ADDR_PEND1) begin
      rd_nxt = pend_r[15:8];
    end else if (addr_i == `VTLIH_ADDR_PEND2) begin
      rd_nxt = {2'b00, pend_r[21:16]};
    end else if (addr_i == `VTLIH_ADDR_STATUS) begin
      rd_nxt = {long_call_o, act_hi_r, act_lo_r, req_idx_r};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_i ? rd_nxt : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_global_gate: assert property (
    !glob_en |=> !req_valid_r) else $error("request raised with global enable off");
  chk_disabled_quiet: assert property (
    fire |-> ($past(pend_r & en_vec) & (vtlih_src_t'(1) << req_idx_r)) != '0) else $error("vectored to disabled source");
  chk_call_len: assert property (
    fire |=> long_call_o [*4] ##1 !long_call_o) else $error("long call not four cycles");
  chk_vector_addr: assert property (
    fire |=> vector_o == (16'h0003 + {8'h00, $past(req_idx_r), 3'b000})) else $error("wrong vector");
  chk_hi_nopreempt: assert property (
    act_hi_r |-> !fire) else $error("high routine preempted");
  chk_return_from_interrupt_boundary: assert property (
    instr_done_i && return_from_interrupt_i |=> !long_call_o) else $error("vectored on return boundary");
  chk_equal_waits: assert property (
    fire && act_lo_r |-> req_hi_r) else $error("low routine preempted by low request");
  chk_auto_clear: assert property (
    fire && req_idx_r == 5'd1 && !hw_set[1] && !wr_i |=> !pend_r[1]) else $error("timer0 flag kept");
  chk_keep_flag: assert property (
    fire && req_idx_r > 5'd3 && !wr_i |=> pend_r[$past(req_idx_r)]) else $error("flag cleared by vectoring");
  chk_level_track: assert property (
    !trig0_r && !$past(trig0_r) |-> pend_r[0] == !$past(pins.level[0])) else $error("level flag not tracking");
  chk_nest_record: assert property (
    fire && req_hi_r |=> act_hi_r) else $error("active level not recorded");

  cov_low_call: cover property (fire && !req_hi_r);
  cov_preempt: cover property (fire && act_lo_r);
  cov_return_from_interrupt_then_call: cover property (instr_done_i && return_from_interrupt_i ##[1:20] fire);
endmodule // vtlih_handler

// >>> vtlih_cfg.svh
/*
  constants of the vectored two-level interrupt handler: register offsets,
  field positions, reset values, vector layout and call timing.
  assumes an 8-bit register port and a 50 MHz system clock.
*/
`ifndef VTLIH_CFG_SVH
`define VTLIH_CFG_SVH

`define VTLIH_NUM_SRC 22
`define VTLIH_NUM_PIN 4

// register offsets
`define VTLIH_ADDR_TIMER_CTRL 8'h88
`define VTLIH_ADDR_PRI_EN 8'ha8
`define VTLIH_ADDR_PORT3_FLAG 8'had
`define VTLIH_ADDR_PRI_PRIO 8'hb8
`define VTLIH_ADDR_PEND0 8'hd2
`define VTLIH_ADDR_PEND1 8'hd3
`define VTLIH_ADDR_PEND2 8'hd4
`define VTLIH_ADDR_STATUS 8'hd5
`define VTLIH_ADDR_EXT_EN1 8'he6
`define VTLIH_ADDR_EXT_EN2 8'he7
`define VTLIH_ADDR_EXT_PRIO1 8'hf6
`define VTLIH_ADDR_EXT_PRIO2 8'hf7

// field positions
`define VTLIH_GLOBAL_EN_BIT 7
`define VTLIH_TC_TRIG0_BIT 0
`define VTLIH_TC_PEND0_BIT 1
`define VTLIH_TC_TRIG1_BIT 2
`define VTLIH_TC_PEND1_BIT 3
`define VTLIH_TC_TMR0_BIT 5
`define VTLIH_TC_TMR1_BIT 7
`define VTLIH_P3_POL6_BIT 2
`define VTLIH_P3_POL7_BIT 3
`define VTLIH_P3_PEND6_BIT 5
`define VTLIH_P3_PEND7_BIT 6

// source order numbers
`define VTLIH_SRC_EXT0 0
`define VTLIH_SRC_TMR0 1
`define VTLIH_SRC_EXT1 2
`define VTLIH_SRC_TMR1 3
`define VTLIH_SRC_EXT6 18
`define VTLIH_SRC_EXT7 19

// reset values and masks
`define VTLIH_RST_BYTE 8'h00
`define VTLIH_PRI_PRIO_UNUSED 8'hc0
`define VTLIH_AUTO_CLR_MASK 22'h00000f
`define VTLIH_PIN_SRC_MASK 22'h0c0005

// vectors and timing
`define VTLIH_RESET_VEC 16'h0000
`define VTLIH_VEC_BASE 16'h0003
`define VTLIH_VEC_SHIFT 3
`define VTLIH_LONG_CALL_CYCLES 3'd4

`endif

// >>> vtlih_pkg.sv
/*
  types of the vectored two-level interrupt handler.
  assumes vtlih_cfg.svh for the numbers.
*/
package vtlih_pkg;
  typedef logic [7:0] vtlih_byte_t;
  typedef logic [15:0] vtlih_vec_t;
  typedef logic [21:0] vtlih_src_t;
  typedef logic [4:0] vtlih_idx_t;
  typedef logic [3:0] vtlih_pin_t;
  typedef enum logic [1:0] {
    VTLIH_ST_RUN = 2'b01,
    VTLIH_ST_CALL = 2'b10
  } vtlih_state_t;
endpackage

// >>> vtlih_pin_if.sv
/*
  carrier between the pin synchroniser and the handler core: settled levels
  and one-cycle edge pulses of the four external interrupt pins.
  assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
interface vtlih_pin_if;
  logic [3:0] level;
  logic [3:0] fall;
  logic [3:0] rise;
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface

// >>> vtlih_pin_sync.sv
/*
  three-flop synchroniser for the external interrupt pins; a change counts
  once the second and third flop agree, and edges are derived from that.
  assumes asynchronous pins and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "vtlih_cfg.svh"
module vtlih_pin_sync
  import vtlih_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire vtlih_pkg::vtlih_pin_t pin_i, // raw pins, idle high
  vtlih_pin_if.src pins // settled levels and edges
);
  import vtlih_pkg::*;

  genvar g;
  generate
    for (g = 0; g < `VTLIH_NUM_PIN; g++) begin : gen_pin
      logic s1_r, s2_r, s3_r, lvl_r, fall_r, rise_r;
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
        end else begin
          s1_r <= pin_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          lvl_r <= 1'b1;
          fall_r <= 1'b0;
          rise_r <= 1'b0;
        end else begin
          fall_r <= (s2_r == s3_r) && lvl_r && !s3_r;
          rise_r <= (s2_r == s3_r) && !lvl_r && s3_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign pins.level[g] = lvl_r;
      assign pins.fall[g] = fall_r;
      assign pins.rise[g] = rise_r;
    end
  endgenerate
endmodule // vtlih_pin_sync

// >>> vtlih_seq_model.sv
/*
  sequencer model: runs instructions of LEN cycles back to back, pulses a
  boundary at each end and marks it as a return when asked.
  assumes the handler's clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module vtlih_seq_model #(
  parameter int LEN = 3
) (
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic long_call_i, // call in progress, program frozen
  input wire logic return_from_interrupt_req_i, // make a coming instruction a return
  output logic instr_done_o, // instruction boundary pulse
  output logic return_from_interrupt_o // this boundary is a return
);
  logic [3:0] cnt_r;
  logic return_from_interrupt_pend_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_r <= 4'h0;
      return_from_interrupt_pend_r <= 1'b0;
      instr_done_o <= 1'b0;
      return_from_interrupt_o <= 1'b0;
    end else begin
      instr_done_o <= 1'b0;
      return_from_interrupt_o <= 1'b0;
      // no boundary while the call runs
      if (!long_call_i) begin
        if (cnt_r >= 4'(LEN - 1)) begin
          cnt_r <= 4'h0;
          instr_done_o <= 1'b1;
          return_from_interrupt_o <= return_from_interrupt_pend_r;
          return_from_interrupt_pend_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
      if (return_from_interrupt_req_i) begin
        return_from_interrupt_pend_r <= 1'b1;
      end
    end
  end
endmodule // vtlih_seq_model

// >>> tb_vectored_two_level_interrupt_handler.sv
/*
  self-checking testbench of the interrupt handler: register port tasks,
  flag pulses, pin stimulus and a sequencer model on the far side.
  assumes the register map and call timing of vtlih_cfg.svh.
*/
`timescale 1ns/100ps
`include "vtlih_cfg.svh"
module tb_vectored_two_level_interrupt_handler;
  import vtlih_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  vtlih_byte_t wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  vtlih_src_t src_set_i = '0;
  logic pin0 = 1'b1;
  logic pin1 = 1'b1;
  logic pin6 = 1'b1;
  logic pin7 = 1'b1;
  logic return_from_interrupt_req = 1'b0;
  logic instr_done_i;
  logic return_from_interrupt_i;
  logic long_call_o;
  vtlih_byte_t rd_data_o;
  vtlih_vec_t vector_o;
  int mismatches = 0;
  int checked = 0;
  vtlih_handler dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .src_set_i(src_set_i), .ext_irq_pin_zero_i(pin0),
    .ext_irq_pin_one_i(pin1), .ext6_pin_i(pin6), .ext7_pin_i(pin7), .instr_done_i(instr_done_i),
    .return_from_interrupt_i(return_from_interrupt_i), .long_call_o(long_call_o), .vector_o(vector_o));
  vtlih_seq_model seq (.clk_i(clk_i), .resetn_i(resetn_i), .long_call_i(long_call_o), .return_from_interrupt_req_i(return_from_interrupt_req),
    .instr_done_o(instr_done_i), .return_from_interrupt_o(return_from_interrupt_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(what, {8'h00, rd_data_o}, {8'h00, exp});
  endtask
  task automatic pulse(input int idx);
    @(posedge clk_i);
    src_set_i <= vtlih_src_t'(1) << idx;
    @(posedge clk_i);
    src_set_i <= '0;
  endtask
  task automatic no_call(input string what, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      if (long_call_o !== 1'b0) seen = 1'b1;
    end
    chk(what, {15'h0000, seen}, 16'h0000);
  endtask
  // nb_exp counts boundaries seen before the call, negative skips it
  task automatic wait_call(input string what, input vtlih_vec_t exp, input int nb_exp);
    int n;
    int nb;
    int w;
    n = 0;
    nb = 0;
    w = 0;
    while (long_call_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      if (instr_done_i === 1'b1) nb++;
      n++;
    end
    chk(what, vector_o, exp);
    while (long_call_o === 1'b1 && w < 10) begin
      @(negedge clk_i);
      w++;
    end
    chk("call length", 16'(w), 16'(`VTLIH_LONG_CALL_CYCLES));
    if (nb_exp >= 0) chk("boundaries", 16'(nb), 16'(nb_exp));
  endtask
  task automatic do_return_from_interrupt();
    int n;
    n = 0;
    @(posedge clk_i);
    return_from_interrupt_req <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_req <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (return_from_interrupt_i !== 1'b1 && n < 50);
    chk("return seen", {15'h0000, return_from_interrupt_i}, 16'h0001);
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    src_set_i <= '0;
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    pin6 <= 1'b1;
    pin7 <= 1'b1;
    repeat (n) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset(8);
    @(negedge clk_i);
    chk("vector", vector_o, `VTLIH_RESET_VEC);
    rdchk("priority", `VTLIH_ADDR_PRI_PRIO, `VTLIH_PRI_PRIO_UNUSED);
    rdchk("enable", `VTLIH_ADDR_PRI_EN, 8'h00);
    wr(8'h00, 8'hff);
    rdchk("unmapped", 8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_gate();
    do_reset(4);
    pulse(4);
    rdchk("flag set", `VTLIH_ADDR_PEND0, 8'h10);
    wr(`VTLIH_ADDR_PRI_EN, 8'h80);
    no_call("source off", 20);
    wr(`VTLIH_ADDR_PRI_EN, 8'h10);
    no_call("global off", 20);
    wr(`VTLIH_ADDR_PRI_EN, 8'h90);
    wait_call("enabled", 16'h0023, -1);
    rdchk("flag kept", `VTLIH_ADDR_PEND0, 8'h10);
    do_return_from_interrupt();
    wait_call("reentry", 16'h0023, 1);
    wr(`VTLIH_ADDR_PEND0, 8'h00);
    do_return_from_interrupt();
    no_call("resumed", 30);
    $display("test gate done");
  endtask
  task automatic t_prio();
    do_reset(4);
    wr(`VTLIH_ADDR_EXT_PRIO1, 8'h01);
    pulse(5);
    pulse(4);
    pulse(6);
    wr(`VTLIH_ADDR_EXT_EN1, 8'h01);
    wr(`VTLIH_ADDR_PRI_EN, 8'hb0);
    wait_call("high first", 16'h0033, -1);
    rdchk("status high", `VTLIH_ADDR_STATUS, 8'h40);
    no_call("high kept", 20);
    wr(`VTLIH_ADDR_PEND0, 8'h30);
    do_return_from_interrupt();
    wait_call("order", 16'h0023, 1);
    no_call("equal waits", 20);
    pulse(6);
    wait_call("preempt", 16'h0033, -1);
    rdchk("status nested", `VTLIH_ADDR_STATUS, 8'h60);
    $display("test priority done");
  endtask
  task automatic t_pins();
    do_reset(4);
    wr(`VTLIH_ADDR_TIMER_CTRL, 8'h01);
    wr(`VTLIH_ADDR_PRI_EN, 8'h83);
    pulse(1);
    wait_call("timer0", 16'h000b, -1);
    rdchk("timer0 cleared", `VTLIH_ADDR_TIMER_CTRL, 8'h01);
    do_return_from_interrupt();
    no_call("no reentry", 20);
    @(posedge clk_i);
    pin0 <= 1'b0;
    wait_call("ext0 edge", 16'h0003, -1);
    rdchk("ext0 cleared", `VTLIH_ADDR_TIMER_CTRL, 8'h01);
    do_return_from_interrupt();
    no_call("edge once", 20);
    wr(`VTLIH_ADDR_TIMER_CTRL, 8'h00);
    wait_call("ext0 level", 16'h0003, -1);
    rdchk("level low", `VTLIH_ADDR_TIMER_CTRL, 8'h02);
    @(posedge clk_i);
    pin0 <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdchk("level high", `VTLIH_ADDR_TIMER_CTRL, 8'h00);
    do_return_from_interrupt();
    no_call("level released", 20);
    $display("test pins done");
  endtask
  task automatic t_ext6();
    do_reset(4);
    wr(`VTLIH_ADDR_PORT3_FLAG, 8'h04);
    wr(`VTLIH_ADDR_EXT_PRIO2, 8'h20);
    wr(`VTLIH_ADDR_EXT_EN2, 8'h30);
    wr(`VTLIH_ADDR_PRI_EN, 8'h80);
    @(posedge clk_i);
    pin6 <= 1'b0;
    no_call("falling ignored", 15);
    rdchk("no flag", `VTLIH_ADDR_PORT3_FLAG, 8'h04);
    @(posedge clk_i);
    pin6 <= 1'b1;
    wait_call("rising", 16'h0093, -1);
    rdchk("ext6 kept", `VTLIH_ADDR_PORT3_FLAG, 8'h24);
    @(posedge clk_i);
    pin7 <= 1'b0;
    wait_call("ext7 falling", 16'h009b, -1);
    $display("test ext6 done");
  endtask
  task automatic t_vectors();
    for (int i = 0; i < `VTLIH_NUM_SRC; i++) begin
      if (((`VTLIH_PIN_SRC_MASK >> i) & 22'h1) != 0) continue;
      do_reset(4);
      if (i < 6) begin
        wr(`VTLIH_ADDR_PRI_EN, 8'h80 | (8'h01 << i));
      end else begin
        wr(`VTLIH_ADDR_PRI_EN, 8'h80);
        wr(i < 14 ? `VTLIH_ADDR_EXT_EN1 : `VTLIH_ADDR_EXT_EN2, 8'h01 << (i < 14 ? i - 6 : i - 14));
      end
      wr(8'(`VTLIH_ADDR_PEND0 + i / 8), 8'h01 << (i % 8));
      wait_call("vector", 16'h0003 + 16'(8 * i), -1);
    end
    $display("test vectors done");
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    t_reset();
    t_gate();
    t_prio();
    t_pins();
    t_ext6();
    t_vectors();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
endmodule // tb_vectored_two_level_interrupt_handler
